//--- rtl/lbe_params.svh
`ifndef LBE_PARAMS_SVH
`define LBE_PARAMS_SVH

// reference space, numbered in octal, held here as hex
`define LBE_REF_W 9
`define LBE_NUM_REFS 512
// push-down stack and region nesting depth
`define LBE_STACK_DEPTH 8
`define LBE_DEPTH_W 4
`define LBE_NEST_DEPTH 8
// retentive coils 340-373 octal
`define LBE_RET_COIL_LO 9'h0e0
`define LBE_RET_COIL_HI 9'h0fb
// shift-register references 400-577 octal, usable as latches
`define LBE_RET_SHIFT_LO 9'h100
`define LBE_RET_SHIFT_HI 9'h17f
// stack reset value
`define LBE_STACK_RESET 8'h00
`define LBE_DEPTH_RESET 4'h0

`endif

//--- rtl/lbe_pkg.sv
package lbe_pkg;

    typedef enum logic [3:0] {
        LBE_OP_NOP = 4'b0000,
        LBE_OP_STACK_LOAD_CONTACT = 4'b0001,
        LBE_OP_SERIES = 4'b0010,
        LBE_OP_PARALLEL = 4'b0011,
        LBE_OP_BLOCK_SERIES_COMBINE = 4'b0100,
        LBE_OP_BLOCK_PARALLEL_COMBINE = 4'b0101,
        LBE_OP_COIL = 4'b0110,
        LBE_OP_LATCH_SET = 4'b0111,
        LBE_OP_LATCH_RESET = 4'b1000,
        LBE_OP_REGION_CONTROL_BEGIN = 4'b1001,
        LBE_OP_REGION_CONTROL_END = 4'b1010,
        LBE_OP_TIMER_COIL = 4'b1011,
        LBE_OP_COUNTER_COIL = 4'b1100
    } lbe_op_t;

    typedef struct packed {
        lbe_op_t op;
        logic invert;
        logic [8:0] ref_addr;
    } lbe_instr_t;

    typedef struct packed {
        logic valid;
        logic [8:0] ref_addr;
        logic value;
    } lbe_bit_wr_t;

    typedef struct packed {
        logic valid;
        logic [8:0] ref_addr;
        logic power;
        logic clear;
        logic hold;
    } lbe_tc_t;

endpackage

//--- rtl/lbe_bit_image.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbe_params.svh"

// input/output/internal bit image; retentive ranges never cleared by reset
module lbe_bit_image
    import lbe_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic clear_on_powerup,
    input wire lbe_bit_wr_t eng_wr,
    input wire lbe_bit_wr_t ext_wr,
    input wire logic [8:0] rd_ref,
    output logic rd_value,
    input wire logic [8:0] obs_ref,
    output logic obs_value
);
    logic [`LBE_NUM_REFS-1:0] image;
    logic [`LBE_NUM_REFS-1:0] next_image;

    // per-bit storage; engine write wins over external write
    genvar gi;
    generate
        for (gi = 0; gi < `LBE_NUM_REFS; gi++) begin : g_bit
            localparam logic [8:0] REF = 9'(gi);
            localparam logic RET = ((REF >= `LBE_RET_COIL_LO) && (REF <= `LBE_RET_COIL_HI)) ||
                ((REF >= `LBE_RET_SHIFT_LO) && (REF <= `LBE_RET_SHIFT_HI));
            always_comb begin
                next_image[gi] = image[gi];
                if (!resetn) begin
                    if (!RET && clear_on_powerup) begin
                        next_image[gi] = 1'b0; // RQ9
                    end
                end else if (eng_wr.valid && eng_wr.ref_addr == REF) begin
                    next_image[gi] = eng_wr.value;
                end else if (ext_wr.valid && ext_wr.ref_addr == REF) begin
                    next_image[gi] = ext_wr.value;
                end
            end
            // retentive bits keep their state through reset
            always_ff @(posedge clock) begin
                image[gi] <= next_image[gi]; // RQ8 RQ10
            end
        end
    endgenerate

    // contact read for the engine, combinational
    assign rd_value = image[rd_ref];

    // registered observation port
    always_ff @(posedge clock) begin
        obs_value <= image[obs_ref];
    end
endmodule // lbe_bit_image

`default_nettype wire

//--- rtl/lbe_evaluator.sv
// Overview of operation
// [RQ1] stack holds eight single-bit ON/OFF locations
// [RQ2] stack load shifts locations down, then puts reference status in location 1
// [RQ3] series/parallel contact ANDs/ORs reference with location 1 only
// [RQ4] block combine ANDs/ORs location 1 with location 2 into location 1
// [RQ5] after block combine, locations 3 to 8 move up one
// [RQ6] coil output drives reference to location 1 status
// [RQ7] inverted contact uses the complement of the reference status
// [RQ8] coils 340-373 keep their state across power loss
// [RQ9] non-retentive coils come up OFF when the clear switch is on
// [RQ10] unused shift references 400-577 also act as retentive latches
// [RQ11] latch set turns coil ON when location 1 ON; it stays ON
// [RQ12] latch reset turns coil OFF when rung condition ON
// [RQ13] later set or reset in program order decides the coil
// [RQ14] region begin takes no reference; rung result enables following logic
// [RQ15] enabled region coils follow their own rung logic
// [RQ16] disabled region forces every coil OFF; latch set/reset write nothing there, so latched coils hold
// [RQ17] disabled region clears timers and freezes counters
// [RQ18] region end restores the enable of the next outer level
// [RQ19] nested region enabled only if every enclosing start is true
// [RQ20] program supplies equal counts of region begin and end
// [RQ21] full-stack load drops bottom; short block combine reads location 2 OFF
// [RQ22] one instruction per cycle; stack and nesting cleared each scan start
`timescale 1ns/1ps
`default_nettype none
`include "lbe_params.svh"

module lbe_evaluator
    import lbe_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic clear_on_powerup,
    input wire logic scan_start,
    input wire logic instr_valid,
    input wire lbe_instr_t instr,
    input wire lbe_bit_wr_t ext_wr,
    input wire logic [8:0] obs_ref,
    output logic obs_value,
    output lbe_bit_wr_t coil_wr,
    output lbe_tc_t tc_out,
    output logic top_status,
    output logic [3:0] stack_depth,
    output logic [3:0] region_depth,
    output logic region_enable
);
    // stack state
    logic [`LBE_STACK_DEPTH-1:0] stack;
    logic [`LBE_STACK_DEPTH-1:0] next_stack;
    logic [`LBE_DEPTH_W-1:0] depth;
    logic [`LBE_DEPTH_W-1:0] next_depth;

    // region state: saved enables of outer levels
    logic [`LBE_NEST_DEPTH-1:0] saved_en;
    logic [`LBE_NEST_DEPTH-1:0] next_saved_en;
    logic [`LBE_DEPTH_W-1:0] nest;
    logic [`LBE_DEPTH_W-1:0] next_nest;
    logic enable;
    logic next_enable;

    // registered outputs
    lbe_bit_wr_t next_coil_wr;
    lbe_tc_t next_tc_out;
    logic next_top_status;

    // image interface
    lbe_bit_wr_t eng_wr;
    logic ref_status;
    logic contact;
    logic loc2;
    logic rung;
    logic exec;
    logic do_begin;
    logic do_end;
    logic do_timer;
    logic do_counter;

    // per-location shift sources of the stack
    logic [`LBE_STACK_DEPTH-1:0] pushed;
    logic [`LBE_STACK_DEPTH-1:0] pulled;

    // bit image with retentive ranges
    lbe_bit_image u_image (
        .clock(clock),
        .resetn(resetn),
        .clear_on_powerup(clear_on_powerup),
        .eng_wr(eng_wr),
        .ext_wr(ext_wr),
        .rd_ref(instr.ref_addr),
        .rd_value(ref_status),
        .obs_ref(obs_ref),
        .obs_value(obs_value)
    );

    // operand decode
    always_comb begin
        exec = instr_valid && !scan_start;
        contact = instr.invert ? !ref_status : ref_status; // RQ7
        loc2 = (depth >= `LBE_DEPTH_W'(2)) ? stack[1] : 1'b0; // RQ21
        rung = stack[0] & enable; // RQ15 RQ16
    end

    // opcode flags of the accepted instruction for region and timer logic
    always_comb begin
        do_begin = 1'b0;
        do_end = 1'b0;
        do_timer = 1'b0;
        do_counter = 1'b0;
        if (exec) begin
            unique case (instr.op)
                LBE_OP_REGION_CONTROL_BEGIN: begin
                    do_begin = 1'b1;
                end
                LBE_OP_REGION_CONTROL_END: begin
                    do_end = 1'b1;
                end
                LBE_OP_TIMER_COIL: begin
                    do_timer = 1'b1;
                end
                LBE_OP_COUNTER_COIL: begin
                    do_counter = 1'b1;
                end
                LBE_OP_NOP,
                LBE_OP_STACK_LOAD_CONTACT,
                LBE_OP_SERIES,
                LBE_OP_PARALLEL,
                LBE_OP_BLOCK_SERIES_COMBINE,
                LBE_OP_BLOCK_PARALLEL_COMBINE,
                LBE_OP_COIL,
                LBE_OP_LATCH_SET,
                LBE_OP_LATCH_RESET: begin
                    do_begin = 1'b0;
                end
                default: begin
                    do_begin = 1'b0;
                end
            endcase
        end
    end

    // a push takes the upper neighbour, a block combine pulls up the lower one
    genvar gl;
    generate
        for (gl = 0; gl < `LBE_STACK_DEPTH; gl++) begin : g_loc
            if (gl == 0) begin : g_top
                // location 1 takes the new contact; a combine keeps it in place and folds location 2 into it
                assign pushed[gl] = contact; // RQ2
                assign pulled[gl] = stack[gl];
            end else if (gl == `LBE_STACK_DEPTH - 1) begin : g_bottom
                // old bottom content falls off; nothing moves up into it
                assign pushed[gl] = stack[gl - 1]; // RQ21
                assign pulled[gl] = 1'b0;
            end else begin : g_mid
                assign pushed[gl] = stack[gl - 1]; // RQ2
                assign pulled[gl] = stack[gl + 1]; // RQ5
            end
        end
    endgenerate

    // stack next state
    always_comb begin
        next_stack = stack;
        next_depth = depth;
        if (scan_start) begin
            next_stack = `LBE_STACK_RESET; // RQ22
            next_depth = `LBE_DEPTH_RESET;
        end else if (exec) begin
            unique case (instr.op)
                LBE_OP_STACK_LOAD_CONTACT: begin
                    // bottom location falls off when full
                    next_stack = pushed; // RQ2 RQ21
                    if (depth < `LBE_DEPTH_W'(`LBE_STACK_DEPTH)) begin
                        next_depth = depth + `LBE_DEPTH_W'(1);
                    end
                end
                LBE_OP_SERIES: begin
                    next_stack[0] = stack[0] & contact; // RQ3
                end
                LBE_OP_PARALLEL: begin
                    next_stack[0] = stack[0] | contact; // RQ3
                end
                LBE_OP_BLOCK_SERIES_COMBINE: begin
                    next_stack = pulled; // RQ5
                    next_stack[0] = pulled[0] & loc2; // RQ4
                    if (depth > `LBE_DEPTH_W'(1)) begin
                        next_depth = depth - `LBE_DEPTH_W'(1);
                    end
                end
                LBE_OP_BLOCK_PARALLEL_COMBINE: begin
                    next_stack = pulled; // RQ5
                    next_stack[0] = pulled[0] | loc2; // RQ4
                    if (depth > `LBE_DEPTH_W'(1)) begin
                        next_depth = depth - `LBE_DEPTH_W'(1);
                    end
                end
                LBE_OP_NOP,
                LBE_OP_COIL,
                LBE_OP_LATCH_SET,
                LBE_OP_LATCH_RESET,
                LBE_OP_REGION_CONTROL_BEGIN,
                LBE_OP_REGION_CONTROL_END,
                LBE_OP_TIMER_COIL,
                LBE_OP_COUNTER_COIL: begin
                    next_stack = stack;
                end
                default: begin
                    next_stack = stack;
                end
            endcase
        end
    end

    // stack registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            stack <= `LBE_STACK_RESET; // RQ1
            depth <= `LBE_DEPTH_RESET;
        end else begin
            stack <= next_stack;
            depth <= next_depth;
        end
    end

    // region nesting next state
    always_comb begin
        next_saved_en = saved_en;
        next_nest = nest;
        next_enable = enable;
        if (scan_start) begin
            next_saved_en = '0; // RQ22
            next_nest = `LBE_DEPTH_RESET;
            next_enable = 1'b1;
        end else if (do_begin) begin
            // reference is ignored; rung result ANDs with outer enable
            next_saved_en = {saved_en[`LBE_NEST_DEPTH-2:0], enable};
            next_enable = enable & stack[0]; // RQ14 RQ19
            if (nest < `LBE_DEPTH_W'(`LBE_NEST_DEPTH)) begin
                next_nest = nest + `LBE_DEPTH_W'(1);
            end
        end else if (do_end) begin
            // unmatched end leaves outermost enable on
            if (nest != `LBE_DEPTH_RESET) begin
                next_enable = saved_en[0]; // RQ18 RQ20
                next_saved_en = {1'b1, saved_en[`LBE_NEST_DEPTH-1:1]};
                next_nest = nest - `LBE_DEPTH_W'(1);
            end else begin
                next_enable = 1'b1;
            end
        end
    end

    // region registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            saved_en <= '0;
            nest <= `LBE_DEPTH_RESET;
            enable <= 1'b1;
        end else begin
            saved_en <= next_saved_en;
            nest <= next_nest;
            enable <= next_enable;
        end
    end

    // image write from coil and latch instructions
    always_comb begin
        eng_wr = '0;
        eng_wr.ref_addr = instr.ref_addr;
        if (exec) begin
            unique case (instr.op)
                LBE_OP_COIL: begin
                    eng_wr.valid = 1'b1;
                    eng_wr.value = rung; // RQ6 RQ16
                end
                LBE_OP_LATCH_SET: begin
                    // no write when condition off, so the latch holds
                    eng_wr.valid = rung; // RQ11 RQ13
                    eng_wr.value = 1'b1;
                end
                LBE_OP_LATCH_RESET: begin
                    eng_wr.valid = rung; // RQ12 RQ13
                    eng_wr.value = 1'b0;
                end
                LBE_OP_TIMER_COIL,
                LBE_OP_COUNTER_COIL: begin
                    eng_wr.valid = 1'b1;
                    eng_wr.value = rung; // RQ16
                end
                LBE_OP_NOP,
                LBE_OP_STACK_LOAD_CONTACT,
                LBE_OP_SERIES,
                LBE_OP_PARALLEL,
                LBE_OP_BLOCK_SERIES_COMBINE,
                LBE_OP_BLOCK_PARALLEL_COMBINE,
                LBE_OP_REGION_CONTROL_BEGIN,
                LBE_OP_REGION_CONTROL_END: begin
                    eng_wr.valid = 1'b0;
                end
                default: begin
                    eng_wr.valid = 1'b0;
                end
            endcase
        end
    end

    // output next values
    always_comb begin
        next_coil_wr = eng_wr;
        next_tc_out = '0;
        next_tc_out.ref_addr = instr.ref_addr;
        next_top_status = next_stack[0];
        if (do_timer) begin
            next_tc_out.valid = 1'b1;
            next_tc_out.power = rung;
            next_tc_out.clear = !enable; // RQ17
        end else if (do_counter) begin
            next_tc_out.valid = 1'b1;
            next_tc_out.power = rung;
            next_tc_out.hold = !enable; // RQ17
        end
    end

    // output registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            coil_wr <= '0;
            tc_out <= '0;
            top_status <= 1'b0;
            stack_depth <= `LBE_DEPTH_RESET;
            region_depth <= `LBE_DEPTH_RESET;
            region_enable <= 1'b1;
        end else begin
            coil_wr <= next_coil_wr;
            tc_out <= next_tc_out;
            top_status <= next_top_status;
            stack_depth <= next_depth;
            region_depth <= next_nest;
            region_enable <= next_enable;
        end
    end
endmodule // lbe_evaluator

`default_nettype wire

//--- tb/lbe_prog_src.sv
`timescale 1ns/1ps
`default_nettype none

// program memory model: scan start pulse, then one word per cycle in order
module lbe_prog_src
    import lbe_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire lbe_instr_t prog [0:31],
    input wire logic run,
    input wire logic [5:0] run_len,
    output logic scan_start,
    output logic instr_valid,
    output lbe_instr_t instr,
    output logic busy
);
    logic [5:0] pc;

    // idle bus toggles so no stale word lingers
    always_ff @(posedge clock) begin
        scan_start <= run && !busy && resetn;
        instr_valid <= busy && pc != run_len;
        instr <= !resetn ? '0 : busy ? prog[pc[4:0]] : lbe_instr_t'(~instr);
        pc <= busy ? pc + 6'h01 : 6'h00;
        busy <= resetn && (busy ? pc != run_len : run);
    end
endmodule // lbe_prog_src

`default_nettype wire

//--- tb/lbe_chk.sv
`timescale 1ns/1ps
`default_nettype none

module lbe_chk
    import lbe_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic scan_start,
    input wire logic instr_valid,
    input wire lbe_instr_t instr,
    input wire lbe_bit_wr_t coil_wr,
    input wire lbe_tc_t tc_out,
    input wire logic top_status,
    input wire logic [3:0] stack_depth,
    input wire logic [3:0] region_depth,
    input wire logic region_enable
);
    logic go;
    lbe_op_t op;

    // accepted instruction and its opcode
    assign go = instr_valid && !scan_start;
    assign op = instr.op;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_scan_clear: assert property (
        scan_start |=> stack_depth == 4'h0 && region_depth == 4'h0 && region_enable)
        else $error("scan start left state");
    a_load_push: assert property (
        go && op == LBE_OP_STACK_LOAD_CONTACT && stack_depth < 4'h8
        |=> stack_depth == $past(stack_depth) + 4'h1) else $error("load depth wrong");
    a_load_full: assert property (
        go && op == LBE_OP_STACK_LOAD_CONTACT && stack_depth == 4'h8
        |=> stack_depth == 4'h8) else $error("full stack grew");
    a_series_low: assert property (
        go && op == LBE_OP_SERIES && !top_status
        |=> !top_status && $stable(stack_depth)) else $error("series raised top");
    a_block_pop: assert property (
        go && (op == LBE_OP_BLOCK_SERIES_COMBINE || op == LBE_OP_BLOCK_PARALLEL_COMBINE)
        && stack_depth > 4'h1 |=> stack_depth == $past(stack_depth) - 4'h1)
        else $error("block depth wrong");
    a_coil_value: assert property (
        go && op == LBE_OP_COIL |=> coil_wr.valid && coil_wr.ref_addr == $past(instr.ref_addr)
        && coil_wr.value == ($past(top_status) && $past(region_enable)))
        else $error("coil write wrong");
    a_region_off: assert property (
        go && op == LBE_OP_REGION_CONTROL_BEGIN && region_depth < 4'h8
        && !(top_status && region_enable) |=> !region_enable) else $error("region not off");
    a_region_close: assert property (
        go && op == LBE_OP_REGION_CONTROL_END && region_depth == 4'h1
        |=> region_enable && region_depth == 4'h0) else $error("region not closed");
    a_timer_clear: assert property (
        go && op == LBE_OP_TIMER_COIL |=> tc_out.valid && tc_out.clear == !$past(region_enable)
        && !tc_out.hold) else $error("timer clear wrong");
    a_counter_hold: assert property (
        go && op == LBE_OP_COUNTER_COIL |=> tc_out.valid && tc_out.hold == !$past(region_enable)
        && !tc_out.clear) else $error("counter hold wrong");
endmodule // lbe_chk

bind lbe_evaluator lbe_chk chk_i (.clock(clock), .resetn(resetn), .scan_start(scan_start),
    .instr_valid(instr_valid), .instr(instr), .coil_wr(coil_wr), .tc_out(tc_out),
    .top_status(top_status), .stack_depth(stack_depth), .region_depth(region_depth),
    .region_enable(region_enable));

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import lbe_pkg::*;
    localparam lbe_op_t ld = LBE_OP_STACK_LOAD_CONTACT, sr = LBE_OP_SERIES;
    localparam lbe_op_t pl = LBE_OP_PARALLEL, bs = LBE_OP_BLOCK_SERIES_COMBINE;
    localparam lbe_op_t bp = LBE_OP_BLOCK_PARALLEL_COMBINE, co = LBE_OP_COIL;
    localparam lbe_op_t st = LBE_OP_LATCH_SET, rs = LBE_OP_LATCH_RESET;
    localparam lbe_op_t rb = LBE_OP_REGION_CONTROL_BEGIN, re = LBE_OP_REGION_CONTROL_END;
    localparam lbe_op_t tm = LBE_OP_TIMER_COIL, cn = LBE_OP_COUNTER_COIL;
    logic clock = 1'b0;
    logic resetn, clr, scan_start, instr_valid, busy, run, obs_value, top_status, r;
    logic region_enable;
    logic [3:0] stack_depth, region_depth;
    logic [5:0] run_len;
    logic [8:0] obs_ref, v, k;
    lbe_instr_t instr, prog [0:31];
    lbe_bit_wr_t ext_wr, coil_wr;
    lbe_tc_t tc_out;
    logic [9:0] q[$];
    logic [11:0] qt[$];
    logic [11:0] t;
    int error_cnt = 0, samples_checked = 0, n = 0;

    // 125 MHz clock
    always #4 clock = ~clock;

    lbe_evaluator dut (.clock(clock), .resetn(resetn), .clear_on_powerup(clr),
        .scan_start(scan_start), .instr_valid(instr_valid), .instr(instr), .ext_wr(ext_wr),
        .obs_ref(obs_ref), .obs_value(obs_value), .coil_wr(coil_wr), .tc_out(tc_out),
        .top_status(top_status), .stack_depth(stack_depth), .region_depth(region_depth),
        .region_enable(region_enable));
    lbe_prog_src src (.clock(clock), .resetn(resetn), .prog(prog), .run(run),
        .run_len(run_len), .scan_start(scan_start), .instr_valid(instr_valid),
        .instr(instr), .busy(busy));

    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic put(input lbe_op_t op, input logic inv, input logic [8:0] ra);
        prog[n] = '{op, inv, ra};
        n++;
    endtask
    task automatic coil(input logic [8:0] ra, input logic val);
        put(co, 1'b0, ra);
        q.push_back({ra, val});
    endtask
    task automatic tmc(input lbe_op_t op, input logic [8:0] ra, input logic on);
        put(op, 1'b0, ra);
        qt.push_back({ra, on, op == tm && !on, op == cn && !on});
    endtask
    task automatic scan();
        int i;
        run_len = 6'(n);
        @(posedge clock);
        #1 run = 1'b1;
        @(posedge clock);
        #1 run = 1'b0;
        for (i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clock);
        if (i == 60) begin
            chk("scan_end", 10'h001, 10'h000);
            summarize();
        end
        repeat (3) @(posedge clock);
        #1 n = 0;
    endtask
    task automatic setb(input logic [8:0] ra, input logic val);
        @(posedge clock);
        #1 ext_wr = '{1'b1, ra, val};
        @(posedge clock);
        #1 ext_wr = '0;
    endtask
    task automatic peek(input logic [8:0] ra, input logic val);
        @(posedge clock);
        #1 obs_ref = ra;
        repeat (2) @(posedge clock);
        #1 chk("image_bit", 10'(obs_value), 10'(val));
    endtask

    // each coil write to a reference below 340 octal is matched against the oldest note
    always @(negedge clock) begin
        if (resetn === 1'b1 && coil_wr.valid === 1'b1 && coil_wr.ref_addr < 9'h0e0) begin
            if (q.size() == 0) begin
                chk("coil_extra", 10'h001, 10'h000);
            end else begin
                chk("coil_wr", {coil_wr.ref_addr, coil_wr.value}, q.pop_front());
            end
        end
        if (resetn === 1'b1 && tc_out.valid === 1'b1) begin
            if (qt.size() == 0) begin
                chk("tc_extra", 10'h001, 10'h000);
            end else begin
                t = qt.pop_front();
                chk("tc_ref", 10'(tc_out.ref_addr), 10'(t[11:3]));
                chk("tc_flags", 10'({tc_out.power, tc_out.clear, tc_out.hold}), 10'(t[2:0]));
            end
        end
    end

    initial begin
        run = 1'b0;
        run_len = 6'h00;
        obs_ref = 9'h000;
        ext_wr = '0;
        clr = 1'b1;
        resetn = 1'b0;
        v = 9'($urandom(89));
        repeat (4) @(posedge clock);
        #1 resetn = 1'b1;
        chk("reset_state", {1'b0, stack_depth, region_depth, region_enable}, 10'h001);
        setb(9'h005, 1'b1);
        setb(9'h006, 1'b0);
        // nine loads overflow the stack, random block folds, contacts, short combine
        repeat (3) begin
            v = 9'($urandom);
            k = 9'($urandom);
            for (int i = 0; i < 9; i++) setb(9'h010 + 9'(i), v[i]);
            for (int i = 0; i < 9; i++) put(ld, 1'b0, 9'h010 + 9'(i));
            r = v[8];
            for (int i = 7; i > 0; i--) begin
                put(k[i] ? bs : bp, 1'b0, 9'h000);
                r = k[i] ? (r & v[i]) : (r | v[i]);
            end
            put(sr, 1'b1, 9'h011);
            put(pl, 1'b0, 9'h012);
            coil(9'h042, (r & ~v[1]) | v[2]);
            put(bs, 1'b0, 9'h000);
            coil(9'h043, 1'b0);
            scan();
            chk("stack_depth", 10'(stack_depth), 10'h001);
        end
        // latch set holds; later reset through a parallel path wins
        put(ld, 1'b0, 9'h005);
        put(st, 1'b0, 9'h0e0);
        put(ld, 1'b0, 9'h006);
        put(st, 1'b0, 9'h0e0);
        put(ld, 1'b0, 9'h005);
        put(st, 1'b0, 9'h100);
        put(ld, 1'b0, 9'h006);
        put(pl, 1'b0, 9'h005);
        put(rs, 1'b0, 9'h100);
        scan();
        peek(9'h0e0, 1'b1);
        peek(9'h100, 1'b0);
        // nested regions over every pair of start conditions
        for (int e = 0; e < 4; e++) begin
            setb(9'h007, e[0]);
            setb(9'h008, e[1]);
            put(ld, 1'b0, 9'h007);
            put(rb, 1'b0, 9'h000);
            put(ld, 1'b0, 9'h008);
            put(rb, 1'b0, 9'h000);
            put(ld, 1'b0, 9'h005);
            coil(9'h050, e[0] & e[1]);
            tmc(tm, 9'h181, e[0] & e[1]);
            tmc(cn, 9'h182, e[0] & e[1]);
            put(re, 1'b0, 9'h000);
            put(ld, 1'b0, 9'h005);
            coil(9'h051, e[0]);
            put(re, 1'b0, 9'h000);
            put(ld, 1'b0, 9'h005);
            coil(9'h052, 1'b1);
            scan();
            chk("regions", {region_depth, region_enable}, 10'h001);
        end
        // retentive bits survive a reset, others are cleared
        setb(9'h0e4, 1'b1);
        setb(9'h120, 1'b1);
        setb(9'h030, 1'b1);
        resetn = 1'b0;
        repeat (4) @(posedge clock);
        #1 resetn = 1'b1;
        peek(9'h0e4, 1'b1);
        peek(9'h120, 1'b1);
        peek(9'h030, 1'b0);
        chk("coil_left", 10'(q.size()), 10'h000);
        chk("tc_left", 10'(qt.size()), 10'h000);
        summarize();
    end
endmodule // testbench

`default_nettype wire
